// ### core/sic_pkg.sv
package sic_pkg;
  // Register byte addresses
  localparam logic [31:0] ADR_PROC_PEND = 32'h71E0_0000;
  localparam logic [31:0] ADR_PROC_CLR  = 32'h71E0_0004;
  localparam logic [31:0] ADR_SW_SET    = 32'h71E0_0008;
  localparam logic [31:0] ADR_SYS_PEND  = 32'h71E1_0000;
  localparam logic [31:0] ADR_SYS_MASK  = 32'h71E1_0004;
  localparam logic [31:0] ADR_MASK_CLR  = 32'h71E1_0008;
  localparam logic [31:0] ADR_MASK_SET  = 32'h71E1_000C;
  localparam logic [31:0] ADR_MODEM     = 32'h71E1_0010;
  localparam logic [31:0] ADR_CFG       = 32'h7018_0000;
  // Processor group layout
  localparam int PEND_SW_LO = 17;
  localparam int PEND_HW_LO = 1;
  localparam int CLR_TOP    = 15;
  // System group layout
  localparam int SYS_GLOBAL = 31;
  localparam int SYS_MODF   = 30;
  localparam int SYS_FLOPPY = 22;
  localparam int SYS_TMR10  = 19;
  localparam int SYS_SCSI   = 18;
  localparam int SYS_ETH    = 16;
  localparam int SYS_SERIAL = 15;
  localparam int SYS_KBD    = 14;
  localparam int SYS_BUS_LO = 7;
  // Option configuration and modem register layout
  localparam int CFG_MODE     = 0;
  localparam int CFG_RING_SEL = 1;
  localparam int CFG_DENS     = 2;
  localparam int CFG_PF_EN    = 3;
  localparam int CFG_RING_EN  = 4;
  localparam int CFG_W        = 5;
  localparam int MDM_PEND     = 0;
  localparam int MDM_EDGE     = 1;
  // Levels
  localparam logic [3:0] LVL_PAR   = 4'h3;
  localparam logic [3:0] LVL_SCSI  = 4'h4;
  localparam logic [3:0] LVL_RING  = 4'h5;
  localparam logic [3:0] LVL_ETH   = 4'h6;
  localparam logic [3:0] LVL_ALT   = 4'h8;
  localparam logic [3:0] LVL_TMR10 = 4'hA;
  localparam logic [3:0] LVL_FLOP  = 4'hB;
  localparam logic [3:0] LVL_SER   = 4'hC;
  localparam logic [3:0] LVL_AUDIO = 4'hD;
  localparam logic [3:0] LVL_TMR14 = 4'hE;
  localparam logic [3:0] LVL_TOP   = 4'hF;
  // Bus IRQ n+1 level at nibble n
  localparam logic [27:0] BUS_LVL_MAP = 28'hDB9_7532;
  // Reset values
  localparam logic [31:0] MASK_RST = 32'hFFFF_FFFF;
  localparam logic [4:0]  CFG_RST  = 5'h00;
  localparam logic [10:0] PIN_RST  = 11'h7FF;

  typedef struct packed {
    logic timer10;
    logic floppy;
    logic serial;
    logic kbd_mouse;
    logic audio;
    logic timer14;
    logic parallel;
    logic scsi;
    logic ethernet;
    logic async_err;
    logic powerdown_req;
  } sic_src_s;
endpackage : sic_pkg

// ### core/sic_top.sv
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/100ps
// Notes on behaviour
// - Pending level goes out as 4-bit code; zero means nothing pending.
// - Timer 10, floppy 11, serial/keyboard 12, audio 13, CPU timer 14.
// - Parallel 3, SCSI 4, Ethernet 6, errors and power-down request 15.
// - Bus IRQ1..IRQ7 map to levels 2,3,5,7,9,11,13.
// - Set location sets chosen software pending bits, raising those levels.
// - Clear location clears software bits written one; top clear clears 15.
// - Processor pending is read-only, software and hardware bits per level.
// - System group: readable mask, set and clear locations, read-only pending.
// - Mask bit 31 disables everything; reserved in system pending.
// - System bits: 30,22,19,18,16,15,14 and 13..7 for bus IRQ7..1.
// - Reset clears configuration; its bits 7..5 read zero.
// - Configuration bit 4 enables modem ring interrupts; off means none.
// - Bit 3 set: low power-fail raises level 15; clear: ignored.
// - Bit 2 picks density select or second motor enable for density pin.
// - Bit 1 set: low ring gives 15; clear: chosen edge gives 5.
// - The ring path not selected sees its input held inactive.
// - Bit 0 picks shared pin use; alternate interrupts dead in mode 0.
module sic_top
  import sic_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire sic_src_s    src_i,
  input  wire logic [7:1]  bus_irq_n_i,
  input  wire logic        power_fail_input_n_i,
  input  wire logic        ring_indicate_input_n_i,
  input  wire logic        shared_pin_a_i,
  input  wire logic        shared_pin_b_i,
  input  wire logic        fdc_density_sel_i,
  input  wire logic        fdc_motor2_en_i,
  output logic      [3:0]  processor_level_lines_o,
  output logic             floppy_density_pin_o,
  output logic             serial_b_clk_o,
  output logic             core_fault_input_n_o
);

  logic [31:0] mask_ff;
  logic [4:0]  cfg_ff;
  logic [15:1] sw_ff;
  logic        top_ff;
  logic        modem_pend_ff;
  logic        edge_sel_ff;
  logic        ring_prev_ff;
  logic [10:0] sync1_ff;
  logic [10:0] sync2_ff;
  logic [10:0] sync3_ff;
  logic [10:0] pin_ff;
  logic        ack_ff;
  logic [31:0] dat_ff;
  logic [3:0]  level_ff;
  logic        dens_ff;
  logic        sclk_ff;
  logic        cfault_ff;

  logic        req;
  logic        wr;
  logic [31:0] wd;
  logic [31:0] rd_val;
  logic [6:0]  bus_act;
  logic        pf_low;
  logic        ring_filt;
  logic        alt_a;
  logic        alt_b;
  logic        alt_req;
  logic        pf_fault;
  logic        ring_lvl_src;
  logic        ring_edge_src;
  logic        ring_lvl15;
  logic        ring_hit;
  logic        top_set;
  logic [15:0] hw_raw;
  logic [15:0] hw_eff;
  logic [15:0] eff;
  logic [3:0]  lv;
  logic [3:0]  nxt_level;
  logic [31:0] sys_pend;

  // Pin filter: bits 6:0 bus IRQ, 7 power fail, 8 ring, 9 pin a, 10 pin b
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_ff <= PIN_RST;
      sync2_ff <= PIN_RST;
      sync3_ff <= PIN_RST;
      pin_ff   <= PIN_RST;
    end else begin
      sync1_ff <= {shared_pin_b_i, shared_pin_a_i, ring_indicate_input_n_i,
                   power_fail_input_n_i, bus_irq_n_i};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      // A bit changes only once two stages agree, so a single glitch is dropped
      pin_ff   <= (sync2_ff & ~(sync2_ff ^ sync3_ff)) | (pin_ff & (sync2_ff ^ sync3_ff));
    end
  end

  assign bus_act   = ~pin_ff[6:0];
  assign pf_low    = ~pin_ff[7];
  assign ring_filt = pin_ff[8];
  assign alt_a     = cfg_ff[CFG_MODE] & ~pin_ff[9];
  assign alt_b     = cfg_ff[CFG_MODE] & pin_ff[10];
  assign alt_req   = alt_a | alt_b;

  // Wishbone classic slave, one wait state; writes land on the ack edge
  assign req = wb_cyc_i & wb_stb_i;
  assign wr  = req & wb_we_i & ack_ff;
  assign wd  = wb_dat_i & {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                           {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= req & ~ack_ff;
      if (req & ~ack_ff) begin
        dat_ff <= rd_val;
      end
    end
  end

  always_comb begin
    sys_pend                           = 32'h0000_0000;
    sys_pend[SYS_MODF]                 = top_ff;
    sys_pend[SYS_FLOPPY]               = src_i.floppy;
    sys_pend[SYS_TMR10]                = src_i.timer10;
    sys_pend[SYS_SCSI]                 = src_i.scsi;
    sys_pend[SYS_ETH]                  = src_i.ethernet;
    sys_pend[SYS_SERIAL]               = src_i.serial;
    sys_pend[SYS_KBD]                  = src_i.kbd_mouse;
    sys_pend[SYS_BUS_LO +: 7]          = bus_act;
  end

  // Write-only locations and unmapped addresses read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (wb_adr_i)
      ADR_PROC_PEND: begin
        rd_val[PEND_SW_LO +: 15] = sw_ff;
        rd_val[PEND_HW_LO +: 15] = hw_raw[15:1];
      end
      ADR_SYS_PEND: rd_val = sys_pend;
      ADR_SYS_MASK: rd_val = mask_ff;
      ADR_CFG:      rd_val[CFG_W-1:0] = cfg_ff;
      ADR_MODEM: begin
        rd_val[MDM_PEND] = modem_pend_ff;
        rd_val[MDM_EDGE] = edge_sel_ff;
      end
      default:      rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_ff <= MASK_RST;
    end else if (wr && wb_adr_i == ADR_MASK_SET) begin
      mask_ff <= mask_ff | wd;
    end else if (wr && wb_adr_i == ADR_MASK_CLR) begin
      mask_ff <= mask_ff & ~wd;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_ff <= CFG_RST;
    end else if (wr && wb_sel_i[0] && wb_adr_i == ADR_CFG) begin
      cfg_ff <= wb_dat_i[CFG_W-1:0];
    end
  end

  // Software bits hold until cleared (set and clear sit at different addresses)
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_ff <= '0;
    end else if (wr && wb_adr_i == ADR_SW_SET) begin
      sw_ff <= sw_ff | wd[PEND_SW_LO +: 15];
    end else if (wr && wb_adr_i == ADR_PROC_CLR) begin
      sw_ff <= sw_ff & ~wd[PEND_SW_LO +: 15];
    end
  end

  // Ring paths: the unselected one sees an inactive-high input.
  // The edge path is also gated off while unselected: forcing it high would
  // otherwise look like a rising edge when bit 1 is set with the ring low.
  assign ring_lvl_src  = cfg_ff[CFG_RING_SEL] ? ring_filt : 1'b1;
  assign ring_edge_src = cfg_ff[CFG_RING_SEL] ? 1'b1 : ring_filt;
  assign ring_lvl15    = cfg_ff[CFG_RING_EN] & ~ring_lvl_src;
  assign ring_hit      = cfg_ff[CFG_RING_EN] & ~cfg_ff[CFG_RING_SEL] &
                         (edge_sel_ff ? (~ring_prev_ff & ring_edge_src)
                                      : (ring_prev_ff & ~ring_edge_src));
  assign pf_fault      = cfg_ff[CFG_PF_EN] & pf_low;
  assign top_set       = src_i.async_err | src_i.powerdown_req | pf_fault | ring_lvl15;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ring_prev_ff <= 1'b1;
    end else begin
      ring_prev_ff <= ring_edge_src;
    end
  end

  // New ring edge wins over a clearing write in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      modem_pend_ff <= 1'b0;
      edge_sel_ff   <= 1'b0;
    end else begin
      if (ring_hit) begin
        modem_pend_ff <= 1'b1;
      end else if (wr && wb_sel_i[0] && wb_adr_i == ADR_MODEM && !wb_dat_i[MDM_PEND]) begin
        modem_pend_ff <= 1'b0;
      end
      if (wr && wb_sel_i[0] && wb_adr_i == ADR_MODEM) begin
        edge_sel_ff <= wb_dat_i[MDM_EDGE];
      end
    end
  end

  // Level-15 faults are latched so a brief error is not missed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      top_ff <= 1'b0;
    end else if (top_set) begin
      top_ff <= 1'b1;
    end else if (wr && wb_sel_i[1] && wb_adr_i == ADR_PROC_CLR && wb_dat_i[CLR_TOP]) begin
      top_ff <= 1'b0;
    end
  end

  always_comb begin
    hw_raw = 16'h0000;
    hw_eff = 16'h0000;
    lv     = 4'h0;
    for (int n = 0; n < 7; n++) begin
      lv         = BUS_LVL_MAP[4*n +: 4];
      hw_raw[lv] = hw_raw[lv] | bus_act[n];
      hw_eff[lv] = hw_eff[lv] | (bus_act[n] & ~mask_ff[SYS_BUS_LO + n]);
    end
    hw_raw[LVL_PAR]   = hw_raw[LVL_PAR] | src_i.parallel;
    hw_eff[LVL_PAR]   = hw_eff[LVL_PAR] | src_i.parallel;
    hw_raw[LVL_SCSI]  = src_i.scsi;
    hw_eff[LVL_SCSI]  = src_i.scsi & ~mask_ff[SYS_SCSI];
    hw_raw[LVL_RING]  = hw_raw[LVL_RING] | modem_pend_ff;
    hw_eff[LVL_RING]  = hw_eff[LVL_RING] | modem_pend_ff;
    hw_raw[LVL_ETH]   = src_i.ethernet;
    hw_eff[LVL_ETH]   = src_i.ethernet & ~mask_ff[SYS_ETH];
    hw_raw[LVL_ALT]   = alt_req;
    hw_eff[LVL_ALT]   = alt_req;
    hw_raw[LVL_TMR10] = src_i.timer10;
    hw_eff[LVL_TMR10] = src_i.timer10 & ~mask_ff[SYS_TMR10];
    hw_raw[LVL_FLOP]  = hw_raw[LVL_FLOP] | src_i.floppy;
    hw_eff[LVL_FLOP]  = hw_eff[LVL_FLOP] | (src_i.floppy & ~mask_ff[SYS_FLOPPY]);
    hw_raw[LVL_SER]   = src_i.serial | src_i.kbd_mouse;
    hw_eff[LVL_SER]   = (src_i.serial & ~mask_ff[SYS_SERIAL]) |
                        (src_i.kbd_mouse & ~mask_ff[SYS_KBD]);
    hw_raw[LVL_AUDIO] = hw_raw[LVL_AUDIO] | src_i.audio;
    hw_eff[LVL_AUDIO] = hw_eff[LVL_AUDIO] | src_i.audio;
    hw_raw[LVL_TMR14] = src_i.timer14;
    hw_eff[LVL_TMR14] = src_i.timer14;
    hw_raw[LVL_TOP]   = top_ff;
    hw_eff[LVL_TOP]   = top_ff & ~mask_ff[SYS_MODF];
  end

  assign eff = ({sw_ff, 1'b0} | hw_eff) & {16{~mask_ff[SYS_GLOBAL]}};

  always_comb begin
    nxt_level = 4'h0;
    for (int l = 1; l < 16; l++) begin
      if (eff[l]) begin
        nxt_level = 4'(l);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_ff <= 4'h0;
    end else begin
      level_ff <= nxt_level;
    end
  end

  // Shared pins follow the filtered inputs, so clock edges lag by five cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dens_ff   <= 1'b0;
      sclk_ff   <= 1'b1;
      cfault_ff <= 1'b1;
    end else begin
      dens_ff   <= cfg_ff[CFG_DENS] ? fdc_density_sel_i : fdc_motor2_en_i;
      sclk_ff   <= cfg_ff[CFG_MODE] ? 1'b1 : pin_ff[9];
      cfault_ff <= cfg_ff[CFG_MODE] ? 1'b1 : pin_ff[10];
    end
  end

  assign wb_ack_o                = ack_ff;
  assign wb_dat_o                = dat_ff;
  assign processor_level_lines_o = level_ff;
  assign floppy_density_pin_o    = dens_ff;
  assign serial_b_clk_o          = sclk_ff;
  assign core_fault_input_n_o    = cfault_ff;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_pf_fault;
    cfg_ff[CFG_PF_EN] && pf_low && !mask_ff[SYS_MODF] && !mask_ff[SYS_GLOBAL];
  endsequence
  sequence s_still_open;
    !mask_ff[SYS_MODF] && !mask_ff[SYS_GLOBAL];
  endsequence

  property p_idle;
    level_ff == 4'h0 |-> $past(eff) == 16'h0000;
  endproperty
  property p_highest;
    level_ff != 4'h0 |-> ($past(eff) >> level_ff) == 16'h0001;
  endproperty
  property p_sw_set;
    (wr && wb_adr_i == ADR_SW_SET) |=>
      (sw_ff & $past(wd[PEND_SW_LO +: 15])) == $past(wd[PEND_SW_LO +: 15]);
  endproperty
  property p_sw_clr;
    (wr && wb_adr_i == ADR_PROC_CLR) |=> (sw_ff & $past(wd[PEND_SW_LO +: 15])) == 15'h0;
  endproperty
  property p_global;
    mask_ff[SYS_GLOBAL] |=> level_ff == 4'h0;
  endproperty
  property p_mask_set;
    (wr && wb_adr_i == ADR_MASK_SET) |=> (mask_ff & $past(wd)) == $past(wd);
  endproperty
  property p_cfg_read;
    wb_ack_o && !wb_we_i && wb_adr_i == ADR_CFG |-> wb_dat_o[7:5] == 3'b000;
  endproperty
  property p_ring_en;
    $rose(modem_pend_ff) |-> $past(cfg_ff[CFG_RING_EN]);
  endproperty
  property p_pf_top;
    s_pf_fault ##1 s_still_open |=> level_ff == LVL_TOP;
  endproperty
  property p_ring_hold;
    cfg_ff[CFG_RING_SEL] |-> !ring_hit;
  endproperty
  property p_density;
    1'b1 |=> dens_ff == $past(cfg_ff[CFG_DENS] ? fdc_density_sel_i : fdc_motor2_en_i);
  endproperty
  property p_mode0;
    !cfg_ff[CFG_MODE] |-> !alt_req ##1 (sclk_ff == $past(pin_ff[9]));
  endproperty
  property p_floppy;
    src_i.floppy && !mask_ff[SYS_FLOPPY] && !mask_ff[SYS_GLOBAL] |=> level_ff >= LVL_FLOP;
  endproperty

  a_idle:      assert property (p_idle)      else $error("level zero while request pending");
  a_highest:   assert property (p_highest)   else $error("level is not the highest pending");
  a_sw_set:    assert property (p_sw_set)    else $error("software set bit not stored");
  a_sw_clr:    assert property (p_sw_clr)    else $error("software clear bit not cleared");
  a_global:    assert property (p_global)    else $error("global disable let a level out");
  a_mask_set:  assert property (p_mask_set)  else $error("mask set bit not stored");
  a_cfg_read:  assert property (p_cfg_read)  else $error("reserved config bits read nonzero");
  a_ring_en:   assert property (p_ring_en)   else $error("modem interrupt while disabled");
  a_pf_top:    assert property (p_pf_top)    else $error("power fail did not reach level 15");
  a_ring_hold: assert property (p_ring_hold) else $error("unselected ring path fired");
  a_density:   assert property (p_density)   else $error("density pin wrong source");
  a_mode0:     assert property (p_mode0)     else $error("alternate interrupt live in mode 0");
  a_floppy:    assert property (p_floppy)    else $error("floppy below level 11");

endmodule : sic_top

// ### dv/sic_cpu_model.sv
`timescale 1ns/100ps
module sic_cpu_model
  import sic_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] level_i,
  output logic      [3:0] taken_level_o
);
  // Core samples the encoded level on every edge; zero means no trap
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      taken_level_o <= 4'h0;
    end else begin
      taken_level_o <= level_i;
    end
  end
endmodule : sic_cpu_model

// ### dv/tb_top.sv
`timescale 1ns/100ps
module tb_top
  import sic_pkg::*;
;
  logic        clk_i, rst_i, cyc, stb, we, ack;
  logic [31:0] adr, wdat, rdat, rd;
  logic [3:0]  sel, lvl, cpu_lvl;
  sic_src_s    src;
  logic [7:1]  bus_n;
  logic        pf_n, ring_n, pin_a, pin_b, dsel, mot2, dens, sclk, cf_n;
  int          bad_count, comparisons;
  logic [3:0]  src_lvl [11] = '{4'hA, 4'hB, 4'hC, 4'hC, 4'hD, 4'hE, 4'h3, 4'h4, 4'h6, 4'hF, 4'hF};
  logic [3:0]  bus_lvl [7] = '{4'h2, 4'h3, 4'h5, 4'h7, 4'h9, 4'hB, 4'hD};

  sic_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .src_i(src), .bus_irq_n_i(bus_n), .power_fail_input_n_i(pf_n),
    .ring_indicate_input_n_i(ring_n), .shared_pin_a_i(pin_a), .shared_pin_b_i(pin_b),
    .fdc_density_sel_i(dsel), .fdc_motor2_en_i(mot2), .processor_level_lines_o(lvl),
    .floppy_density_pin_o(dens), .serial_b_clk_o(sclk), .core_fault_input_n_o(cf_n));

  sic_cpu_model i_cpu (.clk_i(clk_i), .rst_i(rst_i), .level_i(lvl), .taken_level_o(cpu_lvl));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Classic cycle: hold everything until ack is sampled, then release
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      $display("[FAIL] %0t no bus acknowledge", $time);
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask : rd_chk

  // Pins need 4 filter edges, level one more, core sample one more
  task automatic settle;
    repeat (8) @(posedge clk_i);
  endtask : settle

  task automatic lvl_is(input logic [3:0] e);
    settle();
    chk({28'h000_0000, cpu_lvl}, {28'h000_0000, e});
  endtask : lvl_is

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (30000) @(posedge clk_i);
    bad_count++;
    finish_test();
  end

  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, adr, wdat, sel} = '0;
    src = '0;
    bus_n = 7'h7F;
    {pf_n, ring_n, pin_a, pin_b, dsel, mot2} = 6'h3C;
    bad_count = 0;
    comparisons = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(ADR_SYS_MASK, 32'hFFFF_FFFF);
    rd_chk(ADR_CFG, 32'h0000_0000);
    rd_chk(ADR_SW_SET, 32'h0000_0000);
    rd_chk(32'h71E2_0000, 32'h0000_0000);
    wr(ADR_PROC_PEND, 32'hFFFF_FFFF);
    rd_chk(ADR_PROC_PEND, 32'h0000_0000);
    lvl_is(4'h0);
    $display("test registers done");
    wr(ADR_SW_SET, 32'h0020_0000);
    lvl_is(4'h0);
    rd_chk(ADR_PROC_PEND, 32'h0020_0000);
    wr(ADR_MASK_CLR, 32'h8000_0000);
    rd_chk(ADR_SYS_MASK, 32'h7FFF_FFFF);
    lvl_is(4'h5);
    wr(ADR_SW_SET, 32'h8200_0000);
    lvl_is(4'hF);
    wr(ADR_PROC_CLR, 32'h8000_0000);
    lvl_is(4'h9);
    wr(ADR_PROC_CLR, 32'h0200_0000);
    lvl_is(4'h5);
    wr(ADR_PROC_CLR, 32'h0020_0000);
    wr(ADR_SW_SET, 32'h0002_0000);
    lvl_is(4'h1);
    wr(ADR_PROC_CLR, 32'h0002_0000);
    lvl_is(4'h0);
    $display("test software requests done");
    wr(ADR_MASK_CLR, 32'hFFFF_FFFF);
    for (int k = 0; k < 11; k++) begin
      src <= sic_src_s'(11'h400 >> k);
      lvl_is(src_lvl[k]);
      src <= '0;
      settle();
      wr(ADR_PROC_CLR, 32'h0000_8000);
      lvl_is(4'h0);
    end
    for (int k = 1; k < 8; k++) begin
      bus_n <= ~(7'h01 << (k - 1));
      lvl_is(bus_lvl[k - 1]);
      rd_chk(ADR_SYS_PEND, 32'h0000_0001 << (6 + k));
    end
    bus_n <= 7'h7F;
    $display("test source levels done");
    src.floppy <= 1'b1;
    lvl_is(4'hB);
    rd_chk(ADR_SYS_PEND, 32'h0040_0000);
    wr(ADR_MASK_SET, 32'h0040_0000);
    lvl_is(4'h0);
    rd_chk(ADR_SYS_MASK, 32'h0040_0000);
    wr(ADR_MASK_CLR, 32'h0040_0000);
    wr(ADR_SW_SET, 32'h0008_0000);
    wr(ADR_MASK_SET, 32'h8000_0000);
    lvl_is(4'h0);
    rd_chk(ADR_SYS_PEND, 32'h0040_0000);
    rd_chk(ADR_PROC_PEND, 32'h0008_0800);
    wr(ADR_MASK_CLR, 32'h8000_0000);
    lvl_is(4'hB);
    src.floppy <= 1'b0;
    lvl_is(4'h3);
    wr(ADR_PROC_CLR, 32'h0008_0000);
    $display("test masking done");
    wr(ADR_CFG, 32'h0000_00FF);
    rd_chk(ADR_CFG, 32'h0000_001F);
    wr(ADR_CFG, 32'h0000_0004);
    dsel <= 1'b1;
    settle();
    chk(dens, 1'b1);
    wr(ADR_CFG, 32'h0000_0000);
    settle();
    chk(dens, 1'b0);
    mot2 <= 1'b1;
    settle();
    chk(dens, 1'b1);
    $display("test configuration done");
    pf_n <= 1'b0;
    lvl_is(4'h0);
    wr(ADR_CFG, 32'h0000_0008);
    lvl_is(4'hF);
    rd_chk(ADR_SYS_PEND, 32'h4000_0000);
    pf_n <= 1'b1;
    settle();
    wr(ADR_PROC_CLR, 32'h0000_8000);
    lvl_is(4'h0);
    wr(ADR_CFG, 32'h0000_0002);
    ring_n <= 1'b0;
    lvl_is(4'h0);
    wr(ADR_CFG, 32'h0000_0012);
    lvl_is(4'hF);
    ring_n <= 1'b1;
    settle();
    wr(ADR_PROC_CLR, 32'h0000_8000);
    wr(ADR_CFG, 32'h0000_0010);
    ring_n <= 1'b0;
    lvl_is(4'h5);
    wr(ADR_MODEM, 32'h0000_0000);
    lvl_is(4'h0);
    ring_n <= 1'b1;
    lvl_is(4'h0);
    wr(ADR_MODEM, 32'h0000_0002);
    ring_n <= 1'b0;
    lvl_is(4'h0);
    ring_n <= 1'b1;
    lvl_is(4'h5);
    rd_chk(ADR_MODEM, 32'h0000_0003);
    wr(ADR_MODEM, 32'h0000_0002);
    lvl_is(4'h0);
    $display("test power fail and ring done");
    wr(ADR_CFG, 32'h0000_0000);
    pin_a <= 1'b0;
    pin_b <= 1'b0;
    lvl_is(4'h0);
    chk({sclk, cf_n}, 2'b00);
    wr(ADR_CFG, 32'h0000_0001);
    lvl_is(LVL_ALT);
    chk({sclk, cf_n}, 2'b11);
    pin_a <= 1'b1;
    lvl_is(4'h0);
    $display("test pin mode done");
    finish_test();
  end
endmodule : tb_top
